//--- include/psrs_pkg.sv
package psrs_pkg;
  localparam int unsigned PSRS_MSB = 63;
  localparam int unsigned PSRS_IX_FMASK = PSRS_MSB - 13;
  localparam int unsigned PSRS_IX_PEND = PSRS_MSB - 14;
  localparam int unsigned PSRS_IX_WAIT = PSRS_MSB - 16;
  localparam int unsigned PSRS_IX_MM = PSRS_MSB - 18;
  localparam int unsigned PSRS_IX_SQ = PSRS_MSB - 22;
  localparam int unsigned PSRS_IX_PROT = PSRS_MSB - 23;
  localparam int unsigned PSRS_IX_RSET = PSRS_MSB - 27;
  localparam int unsigned PSRS_IX_CC = PSRS_MSB - 31;
  localparam int unsigned PSRS_IX_PA = PSRS_MSB - 63;
  localparam int unsigned PSRS_IX_STAT = 32;
  localparam int unsigned PSRS_HALF_W = 32;
  localparam int unsigned PSRS_RSET_W = 4;
  localparam int unsigned PSRS_CC_W = 4;
  localparam int unsigned PSRS_PA_W = 20;
  localparam int unsigned PSRS_CC_C = 3;
  localparam int unsigned PSRS_CC_V = 2;
  localparam int unsigned PSRS_CC_G = 1;
  localparam int unsigned PSRS_CC_L = 0;
  localparam logic [63:0] PSRS_PSW_VALID = 64'h0006ffff_000fffff;
  localparam logic [63:0] PSRS_PSW_RST = 64'h00000000_00000000;
  localparam logic [31:0] PSRS_IMM_STATUS = 32'h00000000;
  localparam int unsigned PSRS_GPR_W = 32;
  localparam int unsigned PSRS_GPR_AW = 7;
  localparam int unsigned PSRS_GPR_WORDS = 128;
  localparam logic [3:0] PSRS_SET_TOP = 4'h6;
  localparam logic [3:0] PSRS_SET_SPARE = 4'hf;
  localparam logic [3:0] PSRS_SAVE_HI = 4'h0;
  localparam logic [3:0] PSRS_SAVE_LO = 4'h1;
  localparam logic [3:0] PSRS_SAVE_INFO = 4'h2;
  localparam logic [3:0] PSRS_LEN_MIN = 4'h2;
  localparam logic [3:0] PSRS_LEN_MAX = 4'hc;
  localparam logic [7:0] PSRS_OFS_STATUS = 8'h00;
  localparam logic [7:0] PSRS_OFS_LOC = 8'h04;
  localparam logic [7:0] PSRS_OFS_CORE = 8'h08;
  localparam int unsigned PSRS_CORE_FETCH = 0;
  localparam int unsigned PSRS_CORE_UNIMPL = 1;
  localparam int unsigned PSRS_CORE_SAVING = 2;
  localparam int unsigned PSRS_CORE_PEND = 3;
  typedef enum logic [1:0] {
    PSRS_SV_IDLE = 2'b00,
    PSRS_SV_HI = 2'b01,
    PSRS_SV_LO = 2'b10,
    PSRS_SV_INFO = 2'b11
  } psrs_sv_t;
endpackage : psrs_pkg

//--- include/psrs_gpr_if.sv
`timescale 1ns/1ps
interface psrs_gpr_if;
  logic [6:0] ra_addr;
  logic [6:0] rb_addr;
  logic [6:0] rx_addr;
  logic [31:0] ra_data;
  logic [31:0] rb_data;
  logic [31:0] rx_data;
  logic we;
  logic [6:0] waddr;
  logic [31:0] wdata;
  modport mem (input ra_addr, rb_addr, rx_addr, we, waddr, wdata, output ra_data, rb_data, rx_data);
  modport user (output ra_addr, rb_addr, rx_addr, we, waddr, wdata, input ra_data, rb_data, rx_data);
endinterface : psrs_gpr_if

//--- design/psrs_gpr_mem.sv
`timescale 1ns/1ps
module psrs_gpr_mem
  import psrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  psrs_gpr_if.mem gi
);
  logic [PSRS_GPR_W-1:0] store [PSRS_GPR_WORDS];
  logic [PSRS_GPR_W-1:0] a_q;
  logic [PSRS_GPR_W-1:0] b_q;
  logic [PSRS_GPR_W-1:0] x_q;

  // array is not reset; read during write returns the old word
  always_ff @(posedge clk_sys)
  begin
    if (gi.we)
      store[gi.waddr] <= gi.wdata;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_q <= 32'h00000000;
      b_q <= 32'h00000000;
      x_q <= 32'h00000000;
    end
    else
    begin
      a_q <= store[gi.ra_addr];
      b_q <= store[gi.rb_addr];
      x_q <= store[gi.rx_addr];
    end
  end

  assign gi.ra_data = a_q;
  assign gi.rb_data = b_q;
  assign gi.rx_data = x_q;
endmodule : psrs_gpr_mem

//--- design/psrs_loc_next.sv
`timescale 1ns/1ps
module psrs_loc_next
  import psrs_pkg::*;
(
  input wire logic [PSRS_PA_W-1:0] cur,
  input wire logic done,
  input wire logic [3:0] len,
  input wire logic branch,
  input wire logic [PSRS_PA_W-1:0] target,
  input wire logic fault,
  input wire logic bad_branch,
  output logic [PSRS_PA_W-1:0] nxt
);
  wire [PSRS_PA_W-1:0] advanced = PSRS_PA_W'(cur + {16'h0000, len});
  wire keep_target = fault && bad_branch;
  wire keep_cur = fault || !done;

  assign nxt = keep_target ? target :
               keep_cur ? cur :
               branch ? target :
               advanced;
endmodule : psrs_loc_next

//--- design/psrs_core.sv
`timescale 1ns/1ps
module psrs_core
  import psrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic instr_done,
  input wire logic [3:0] instr_len,
  input wire logic branch_taken,
  input wire logic [19:0] branch_target,
  input wire logic instr_fault,
  input wire logic fault_bad_branch,
  input wire logic cc_update,
  input wire logic [3:0] cc_new,
  input wire logic pend_set,
  input wire logic pend_clr,
  input wire logic exec_priv,
  input wire logic mm_req,
  input wire logic sq_req,
  input wire logic irq_take,
  input wire logic [63:0] irq_new_psw,
  input wire logic irq_immediate,
  input wire logic [19:0] irq_imm_loc,
  input wire logic irq_save_regs,
  input wire logic [31:0] irq_info,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  input wire logic [3:0] rd_x_idx,
  input wire logic gpr_we,
  input wire logic [3:0] gpr_wr_idx,
  input wire logic [31:0] gpr_wr_data,
  output logic [63:0] processor_state_word,
  output logic [31:0] op_a,
  output logic [31:0] op_b,
  output logic [31:0] op_x,
  output logic [63:0] old_psw,
  output logic float_masked_mode,
  output logic interruptible_op_pending,
  output logic cc_carry,
  output logic cc_overflow,
  output logic cc_greater,
  output logic cc_less,
  output logic fetch_enable,
  output logic priv_fault,
  output logic mm_irq,
  output logic sq_irq,
  output logic set_unimpl,
  output logic save_busy
);
  psrs_gpr_if gi ();

  logic [63:0] psw_q;
  logic [63:0] psw_d;
  psrs_sv_t sv_q;
  psrs_sv_t sv_d;
  logic [63:0] old_q;
  logic [31:0] info_q;
  logic [31:0] rdata_q;
  logic rd_impl_q;
  logic x_nz_q;
  logic [31:0] core_word;
  logic [PSRS_PA_W-1:0] loc_nxt;

  // a set number maps to a physical bank; 15 lands on bank 7
  function automatic logic set_exists(input logic [3:0] s);
    return (s <= PSRS_SET_TOP) || (s == PSRS_SET_SPARE);
  endfunction : set_exists

  function automatic logic [6:0] gpr_addr(input logic [3:0] s, input logic [3:0] r);
    return {s[2:0], r};
  endfunction : gpr_addr

  // state word fields
  wire [3:0] rset = psw_q[PSRS_IX_RSET +: PSRS_RSET_W];
  wire [3:0] cc = psw_q[PSRS_IX_CC +: PSRS_CC_W];
  wire [PSRS_PA_W-1:0] loc = psw_q[PSRS_IX_PA +: PSRS_PA_W];
  wire [31:0] status_half = psw_q[PSRS_IX_STAT +: PSRS_HALF_W];
  wire [31:0] loc_half = psw_q[0 +: PSRS_HALF_W];
  wire set_impl = set_exists(rset);
  wire waiting = psw_q[PSRS_IX_WAIT];

  // register bus decode
  wire sel_status = bus_addr == PSRS_OFS_STATUS;
  wire sel_loc = bus_addr == PSRS_OFS_LOC;
  wire sel_core = bus_addr == PSRS_OFS_CORE;
  wire wr_status = bus_wr && sel_status;
  wire wr_loc = bus_wr && sel_loc;
  wire bus_psw_wr = wr_status || wr_loc;
  wire [31:0] valid_hi = PSRS_PSW_VALID[PSRS_IX_STAT +: PSRS_HALF_W];
  wire [31:0] valid_lo = PSRS_PSW_VALID[0 +: PSRS_HALF_W];

  // interrupt entry
  wire sv_idle = sv_q == PSRS_SV_IDLE;
  wire irq_go = irq_take && sv_idle;
  wire [63:0] irq_new_ok = irq_new_psw & PSRS_PSW_VALID;
  wire [31:0] imm_loc_half = {{(PSRS_HALF_W - PSRS_PA_W){1'b0}}, irq_imm_loc};
  wire [63:0] imm_psw = {PSRS_IMM_STATUS, imm_loc_half};
  wire [63:0] irq_psw = irq_immediate ? imm_psw : irq_new_ok;

  // instruction events apply only when nothing stronger loads the word
  wire instr_ok = !irq_go && !bus_psw_wr;
  wire cc_take = instr_ok && instr_done && cc_update;

  psrs_loc_next u_loc (
    .cur(loc),
    .done(instr_done),
    .len(instr_len),
    .branch(branch_taken),
    .target(branch_target),
    .fault(instr_fault),
    .bad_branch(fault_bad_branch),
    .nxt(loc_nxt)
  );

  always_comb
  begin
    psw_d = psw_q;
    if (irq_go)
    begin
      psw_d = irq_psw;
    end
    else if (wr_status)
    begin
      psw_d[PSRS_IX_STAT +: PSRS_HALF_W] = bus_wdata & valid_hi;
    end
    else if (wr_loc)
    begin
      psw_d[0 +: PSRS_HALF_W] = bus_wdata & valid_lo;
    end
    else
    begin
      psw_d[PSRS_IX_PA +: PSRS_PA_W] = loc_nxt;
      if (cc_take)
        psw_d[PSRS_IX_CC +: PSRS_CC_W] = cc_new;
      // a set in the same cycle as a clear wins
      if (pend_set)
        psw_d[PSRS_IX_PEND] = 1'b1;
      else if (pend_clr)
        psw_d[PSRS_IX_PEND] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      psw_q <= PSRS_PSW_RST;
    else
      psw_q <= psw_d;
  end

  // old word and interrupt info go to the bank chosen by the new word
  always_comb
  begin
    sv_d = sv_q;
    unique case (sv_q)
      PSRS_SV_IDLE:
      begin
        if (irq_go && irq_save_regs)
          sv_d = PSRS_SV_HI;
        else if (irq_go)
          sv_d = PSRS_SV_INFO;
      end
      PSRS_SV_HI: sv_d = PSRS_SV_LO;
      PSRS_SV_LO: sv_d = PSRS_SV_INFO;
      PSRS_SV_INFO: sv_d = PSRS_SV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sv_q <= PSRS_SV_IDLE;
      old_q <= 64'h00000000_00000000;
      info_q <= 32'h00000000;
    end
    else
    begin
      sv_q <= sv_d;
      if (irq_go)
      begin
        old_q <= psw_q;
        info_q <= irq_info;
      end
    end
  end

  wire sv_hi = sv_q == PSRS_SV_HI;
  wire sv_lo = sv_q == PSRS_SV_LO;
  wire [3:0] sv_reg = sv_hi ? PSRS_SAVE_HI : sv_lo ? PSRS_SAVE_LO : PSRS_SAVE_INFO;
  wire [31:0] old_hi = old_q[PSRS_IX_STAT +: PSRS_HALF_W];
  wire [31:0] old_lo = old_q[0 +: PSRS_HALF_W];
  wire [31:0] sv_data = sv_hi ? old_hi : sv_lo ? old_lo : info_q;
  wire [3:0] wr_reg = sv_idle ? gpr_wr_idx : sv_reg;

  // writes into an unimplemented set are dropped
  assign gi.we = set_impl && (!sv_idle || gpr_we);
  assign gi.waddr = gpr_addr(rset, wr_reg);
  assign gi.wdata = sv_idle ? gpr_wr_data : sv_data;
  assign gi.ra_addr = gpr_addr(rset, rd_a_idx);
  assign gi.rb_addr = gpr_addr(rset, rd_b_idx);
  assign gi.rx_addr = gpr_addr(rset, rd_x_idx);

  psrs_gpr_mem u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .gi(gi.mem)
  );

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_impl_q <= 1'b0;
      x_nz_q <= 1'b0;
    end
    else
    begin
      rd_impl_q <= set_impl;
      x_nz_q <= rd_x_idx != 4'h0;
    end
  end

  assign op_a = rd_impl_q ? gi.ra_data : 32'h00000000;
  assign op_b = rd_impl_q ? gi.rb_data : 32'h00000000;
  assign op_x = (rd_impl_q && x_nz_q) ? gi.rx_data : 32'h00000000;

  always_comb
  begin
    core_word = 32'h00000000;
    core_word[PSRS_CORE_FETCH] = fetch_enable;
    core_word[PSRS_CORE_UNIMPL] = set_unimpl;
    core_word[PSRS_CORE_SAVING] = save_busy;
    core_word[PSRS_CORE_PEND] = interruptible_op_pending;
  end

  wire [31:0] rd_mux = sel_status ? status_half :
                       sel_loc ? loc_half :
                       sel_core ? core_word : 32'h00000000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= bus_rd ? rd_mux : 32'h00000000;
  end

  assign bus_rdata = rdata_q;
  assign processor_state_word = psw_q;
  assign old_psw = old_q;
  assign float_masked_mode = psw_q[PSRS_IX_FMASK];
  assign interruptible_op_pending = psw_q[PSRS_IX_PEND];
  assign cc_carry = cc[PSRS_CC_C];
  assign cc_overflow = cc[PSRS_CC_V];
  assign cc_greater = cc[PSRS_CC_G];
  assign cc_less = cc[PSRS_CC_L];
  assign fetch_enable = !waiting;
  assign priv_fault = exec_priv && psw_q[PSRS_IX_PROT];
  assign mm_irq = mm_req && psw_q[PSRS_IX_MM];
  assign sq_irq = sq_req && psw_q[PSRS_IX_SQ];
  assign set_unimpl = !set_impl;
  assign save_busy = !sv_idle;

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  wire quiet = instr_ok && !instr_done && !instr_fault;
  wire plain_done = instr_ok && instr_done && !instr_fault && !branch_taken;

  AST_LOC_HOLD: assert property (quiet |=> $stable(loc))
    else $error("location counter moved without completion");

  AST_LOC_ADV: assert property (plain_done |=> loc == PSRS_PA_W'($past(loc) + {16'h0000, $past(instr_len)}))
    else $error("location counter did not advance by length");

  AST_BRANCH: assert property (instr_ok && instr_done && branch_taken && !instr_fault
    |=> loc == $past(branch_target))
    else $error("taken branch did not load target");

  AST_FAULT: assert property (instr_ok && instr_fault
    |=> loc == ($past(fault_bad_branch) ? $past(branch_target) : $past(loc)))
    else $error("faulting instruction address not kept");

  AST_CC_HOLD: assert property (!cc_take && !irq_go && !wr_status |=> $stable(cc))
    else $error("result flags changed without cause");

  AST_CC_LOAD: assert property (cc_take |=> cc == $past(cc_new))
    else $error("result flags not loaded");

  AST_PRIV: assert property (exec_priv && psw_q[PSRS_IX_PROT] |-> priv_fault)
    else $error("privileged attempt not flagged");

  AST_IDX0: assert property (rd_x_idx == 4'h0 |=> op_x == 32'h00000000)
    else $error("register 0 used as index");

  AST_SAVE: assert property (irq_go && irq_save_regs
    |=> sv_q == PSRS_SV_HI ##1 sv_q == PSRS_SV_LO ##1 sv_q == PSRS_SV_INFO ##1 sv_idle)
    else $error("old word save sequence broken");

  AST_INFO: assert property (irq_go && !irq_save_regs |=> sv_q == PSRS_SV_INFO ##1 sv_idle)
    else $error("interrupt info not written");

  AST_IMM: assert property (irq_go && irq_immediate
    |=> status_half == PSRS_IMM_STATUS && loc == $past(irq_imm_loc))
    else $error("immediate interrupt word wrong");

  AST_WAIT: assert property (waiting && !irq_go && !wr_status |=> !fetch_enable)
    else $error("fetch enabled in wait state");

  AST_UNIMPL: assert property (!set_impl |-> !gi.we)
    else $error("write into unimplemented set");

  AST_MASKS: assert property (mm_irq |-> mm_req && psw_q[PSRS_IX_MM] ##0 (!sq_irq || psw_q[PSRS_IX_SQ]))
    else $error("interrupt passed its mask");

  AST_FMASK: assert property (wr_status && !irq_go
    |=> float_masked_mode == $past(bus_wdata[PSRS_IX_FMASK - PSRS_IX_STAT]))
    else $error("masked mode bit not taken");
endmodule : psrs_core

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst_n, bus_wr, bus_rd, instr_done, branch_taken, instr_fault, fault_bad_branch, cc_update;
  logic pend_set, pend_clr, exec_priv, mm_req, sq_req, irq_take, irq_immediate, irq_save_regs, gpr_we;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, irq_info, gpr_wr_data, op_a, op_b, op_x, rv;
  logic [3:0] instr_len, cc_new, rd_a_idx, rd_b_idx, rd_x_idx, gpr_wr_idx;
  logic [19:0] branch_target, irq_imm_loc;
  logic [63:0] irq_new_psw, processor_state_word, old_psw;
  logic float_masked_mode, interruptible_op_pending, cc_carry, cc_overflow, cc_greater, cc_less;
  logic fetch_enable, priv_fault, mm_irq, sq_irq, set_unimpl, save_busy;
  int error_cnt;
  int checks_done;

  psrs_core i_psrs_core (
    .clk_sys, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .instr_done, .instr_len,
    .branch_taken, .branch_target, .instr_fault, .fault_bad_branch, .cc_update, .cc_new, .pend_set,
    .pend_clr, .exec_priv, .mm_req, .sq_req, .irq_take, .irq_new_psw, .irq_immediate, .irq_imm_loc,
    .irq_save_regs, .irq_info, .rd_a_idx, .rd_b_idx, .rd_x_idx, .gpr_we, .gpr_wr_idx, .gpr_wr_data,
    .processor_state_word, .op_a, .op_b, .op_x, .old_psw, .float_masked_mode, .interruptible_op_pending,
    .cc_carry, .cc_overflow, .cc_greater, .cc_less, .fetch_enable, .priv_fault, .mm_irq, .sq_irq,
    .set_unimpl, .save_busy
  );

  always #5 clk_sys = ~clk_sys;

  task summarize;
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  task gw(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    gpr_we <= 1'b1;
    gpr_wr_idx <= i;
    gpr_wr_data <= d;
    @(posedge clk_sys);
    gpr_we <= 1'b0;
    #1;
  endtask : gw

  task gr(input logic [3:0] i);
    @(posedge clk_sys);
    rd_a_idx <= i;
    rd_b_idx <= i;
    rd_x_idx <= i;
    @(posedge clk_sys);
    #1;
  endtask : gr

  task ins(input logic d, input logic [3:0] l, input logic b, input logic [19:0] t, input logic f,
           input logic bb, input logic cu, input logic [3:0] c);
    @(posedge clk_sys);
    {instr_done, instr_len, branch_taken, branch_target} <= {d, l, b, t};
    {instr_fault, fault_bad_branch, cc_update, cc_new} <= {f, bb, cu, c};
    @(posedge clk_sys);
    {instr_done, branch_taken, instr_fault, fault_bad_branch, cc_update} <= 5'h00;
    #1;
  endtask : ins

  task t_reset;
    chk(processor_state_word, 64'h0);
    chk({fetch_enable, set_unimpl, save_busy}, 3'b100);
    rd(8'h04, rv);
    chk(rv, 32'h0);
  endtask : t_reset

  task t_regs;
    wr(8'h00, 32'h0006ffff);
    rd(8'h00, rv);
    chk(rv, 32'h0006ffff);
    @(posedge clk_sys);
    #1;
    chk(bus_rdata, 32'h0);
    chk({float_masked_mode, interruptible_op_pending}, 2'b11);
    chk({cc_carry, cc_overflow, cc_greater, cc_less}, 4'hf);
    chk(fetch_enable, 1'b0);
    rd(8'h08, rv);
    chk(rv, 32'h00000008);
    wr(8'h0c, 32'h12345678);
    rd(8'h0c, rv);
    chk(rv, 32'h0);
    chk(processor_state_word[63:32], 32'h0006ffff);
    wr(8'h04, 32'h000fffff);
    chk(processor_state_word, 64'h0006ffff_000fffff);
    wr(8'h00, 32'h0);
    chk({fetch_enable, float_masked_mode}, 2'b10);
  endtask : t_regs

  task t_masks;
    logic [31:0] m [4];
    m = '{32'h00002000, 32'h00000200, 32'h00000100, 32'h0};
    @(posedge clk_sys);
    {mm_req, sq_req, exec_priv} <= 3'b111;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, m[i]);
      chk({mm_irq, sq_irq, priv_fault}, 3'b100 >> i);
    end
  endtask : t_masks

  task t_sets;
    for (int s = 0; s < 16; s++)
    begin
      wr(8'h00, 32'(s) << 4);
      chk(set_unimpl, !(s <= 6 || s == 15));
      gw(4'h5, 32'h5e700000 | 32'(s));
    end
    for (int s = 0; s < 16; s++)
    begin
      wr(8'h00, 32'(s) << 4);
      gr(4'h5);
      chk(op_a, (s <= 6 || s == 15) ? (32'h5e700000 | 32'(s)) : 32'h0);
    end
    wr(8'h00, 32'h00000010);
    gw(4'h0, 32'h11111111);
    gw(4'hf, 32'hffff0001);
    gr(4'h0);
    chk({op_a, op_x}, {32'h11111111, 32'h0});
    gr(4'hf);
    chk({op_a, op_b}, {2{32'hffff0001}});
    chk(op_x, 32'hffff0001);
  endtask : t_sets

  task t_loc;
    logic [19:0] e;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h00001000);
    e = 20'h01000;
    for (int l = 2; l <= 12; l += 2)
    begin
      ins(1'b1, 4'(l), 1'b0, 20'h0, 1'b0, 1'b0, 1'b0, 4'h0);
      e = e + 20'(l);
      chk(processor_state_word[19:0], e);
    end
    repeat (3) @(posedge clk_sys);
    #1;
    chk(processor_state_word[19:0], e);
    ins(1'b1, 4'h4, 1'b1, 20'h0a5a4, 1'b0, 1'b0, 1'b0, 4'h0);
    chk(processor_state_word[19:0], 20'h0a5a4);
    ins(1'b0, 4'h0, 1'b0, 20'h77777, 1'b1, 1'b0, 1'b0, 4'h0);
    chk(processor_state_word[19:0], 20'h0a5a4);
    ins(1'b0, 4'h0, 1'b0, 20'h77776, 1'b1, 1'b1, 1'b0, 4'h0);
    chk(processor_state_word[19:0], 20'h77776);
    for (int i = 0; i < 4; i++)
    begin
      ins(1'b1, 4'h2, 1'b0, 20'h0, 1'b0, 1'b0, 1'b1, 4'h8 >> i);
      chk({cc_carry, cc_overflow, cc_greater, cc_less}, 4'h8 >> i);
      chk(processor_state_word[35:32], 4'h8 >> i);
    end
    ins(1'b1, 4'h2, 1'b0, 20'h0, 1'b0, 1'b0, 1'b0, 4'hf);
    chk(processor_state_word[35:32], 4'h1);
    @(posedge clk_sys);
    {pend_set, pend_clr} <= 2'b10;
    @(posedge clk_sys);
    {pend_set, pend_clr} <= 2'b01;
    #1;
    chk(interruptible_op_pending, 1'b1);
    @(posedge clk_sys);
    {pend_set, pend_clr} <= 2'b11;
    #1;
    chk(interruptible_op_pending, 1'b0);
    @(posedge clk_sys);
    {pend_set, pend_clr} <= 2'b00;
    #1;
    chk(interruptible_op_pending, 1'b1);
  endtask : t_loc

  task t_irq;
    wr(8'h00, 32'h00000010);
    wr(8'h04, 32'h00000abc);
    @(posedge clk_sys);
    {irq_take, irq_save_regs, irq_immediate} <= 3'b110;
    irq_new_psw <= 64'h00040030_00012344;
    irq_info <= 32'hc0ffee01;
    @(posedge clk_sys);
    irq_take <= 1'b0;
    #1;
    chk(processor_state_word, 64'h00040030_00012344);
    chk(old_psw, 64'h00000010_00000abc);
    chk(save_busy, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(save_busy, 1'b0);
    gr(4'h0);
    chk(op_a, 32'h00000010);
    gr(4'h1);
    chk(op_a, 32'h00000abc);
    gr(4'h2);
    chk(op_a, 32'hc0ffee01);
    @(posedge clk_sys);
    {irq_take, irq_save_regs, irq_immediate} <= 3'b101;
    irq_imm_loc <= 20'h2468a;
    @(posedge clk_sys);
    irq_take <= 1'b0;
    #1;
    chk(processor_state_word, 64'h00000000_0002468a);
    repeat (3) @(posedge clk_sys);
  endtask : t_irq

  initial
  begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial
  begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {bus_wr, bus_rd, instr_done, branch_taken, instr_fault, fault_bad_branch, cc_update} = '0;
    {pend_set, pend_clr, exec_priv, mm_req, sq_req, irq_take, irq_immediate, irq_save_regs, gpr_we} = '0;
    {bus_addr, bus_wdata, irq_info, gpr_wr_data, instr_len, cc_new} = '0;
    {rd_a_idx, rd_b_idx, rd_x_idx, gpr_wr_idx, branch_target, irq_imm_loc, irq_new_psw} = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_regs();
    t_masks();
    t_sets();
    t_loc();
    t_irq();
    summarize();
  end
endmodule : tb_top
